// *** core/cpsmc_top.v ***
/*
  processing-state and mode controller: reset, exception entry, bus release,
  power-down entry, access timing and mode decode, with its registers.
  assumes a same-clock core that pulses requests, and a plain register port.
*/
`timescale 1ns/10ps
`include "cpsmc_defines.vh"
module cpsmc_top (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        reset_input_n_i,
  input  wire        hw_standby_input_n_i,
  input  wire [2:0]  mode_pins_i,
  input  wire        wdt_overflow_i,
  input  wire        bus_req_i,
  input  wire        irq_req_i,
  input  wire        trap_req_i,
  input  wire        sleep_exec_i,
  input  wire        wake_i,
  input  wire        access_req_i,
  input  wire [23:0] access_addr_i,
  input  wire [23:0] ram_base_i,
  input  wire [23:0] ram_limit_i,
  input  wire [23:0] periph_base_i,
  input  wire [23:0] periph_limit_i,
  input  wire [2:0]  access_area_i,
  input  wire [19:0] reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg  [2:0]  proc_state_o,
  output reg         bus_grant_o,
  output reg         irq_accept_o,
  output reg         stack_push_o,
  output reg         vector_fetch_o,
  output reg  [7:0]  condition_code_reg_o,
  output reg         periph_reset_o,
  output reg         clock_halt_o,
  output reg         cpu_halt_o,
  output reg         access_done_o,
  output reg  [1:0]  access_target_o,
  output reg         access_wide_o,
  output reg         bus_16bit_o,
  output reg         mode_legal_o,
  output reg  [2:0]  mode_num_o,
  output reg         space_16m_o,
  output reg         rom_enable_o
);
  // access targets
  localparam [1:0] TGT_RAM = 2'h0;
  localparam [1:0] TGT_PER = 2'h1;
  localparam [1:0] TGT_EXT = 2'h2;

  wire       res_n_s;
  wire       hw_standby_input_n_n_s;
  wire [2:0] mode_s;

  // standby idles high so no false standby after reset; reset pin starts low to give a power-on sequence
  cpsmc_sync2 #(.W(2), .INIT(2'h1)) u_sync_ctl (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   ({reset_input_n_i, hw_standby_input_n_i}),
    .sync_o    ({res_n_s, hw_standby_input_n_n_s})
  );
  cpsmc_sync2 #(.W(3), .INIT(3'h0)) u_sync_mode (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .async_i   (mode_pins_i),
    .sync_o    (mode_s)
  );

  // mode decode used for both register view and initial bus mode
  function [3:0] mode_decode;
    input [2:0] pins;
    begin
      case (pins)
        3'h1:    mode_decode = 4'h9; // legal, mode 1, 8-bit
        3'h2:    mode_decode = 4'ha; // legal, mode 2, 16-bit
        3'h3:    mode_decode = 4'hb; // legal, mode 3, 8-bit
        3'h4:    mode_decode = 4'hc; // legal, mode 4, 16-bit
        default: mode_decode = 4'h0;
      endcase
    end
  endfunction

  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [3:0] seq_cnt_q;
  reg        res_n_prev_q;
  reg  [7:0] sys_cfg_q;
  reg  [7:0] area_width_q;
  reg  [7:0] area_slow_q;
  reg  [7:0] ccr_q;
  reg        int_block_q;
  reg  [1:0] tgt_q;
  reg        wide_q;
  reg        wake_pend_q;

  wire [3:0] mode_dec   = mode_decode(mode_s);
  wire       force_rst  = ~res_n_s | wdt_overflow_i;
  // watchdog release restarts the same way as a pin release
  wire       res_rise   = ~force_rst & ~res_n_prev_q;
  wire       all_8bit   = (area_width_q == 8'hff);
  wire       ram_hit    = sys_cfg_q[`CPSMC_ONCHIP_RAM_ENABLE_BIT] &
                          (access_addr_i >= ram_base_i) & (access_addr_i <= ram_limit_i);
  wire       per_hit    = (access_addr_i >= periph_base_i) & (access_addr_i <= periph_limit_i);
  wire [1:0] tgt_d      = ram_hit ? TGT_RAM : (per_hit ? TGT_PER : TGT_EXT);
  wire       three_d    = (tgt_d == TGT_PER) ? 1'b1 :
                          (tgt_d == TGT_RAM) ? 1'b0 :
                          area_slow_q[access_area_i];
  wire       wide_d     = (tgt_d != TGT_EXT) | ~area_width_q[access_area_i];
  wire       timer_busy;
  wire       timer_done;
  wire       exec_run   = (state_q == `CPSMC_ST_EXEC);
  wire       acc_start  = exec_run & access_req_i & ~timer_busy;

  cpsmc_bus_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .start_i   (acc_start),
    .three_i   (three_d),
    .busy_o    (timer_busy),
    .done_o    (timer_done)
  );

  // next processing state; reset and hardware standby override everything
  always @* begin
    state_d = state_q;
    case (state_q)
      `CPSMC_ST_RESET:   if (res_rise) state_d = `CPSMC_ST_RST_EXC;
      `CPSMC_ST_RST_EXC: if (seq_cnt_q == `CPSMC_RST_EXC_STATES) state_d = `CPSMC_ST_EXEC;
      `CPSMC_ST_EXEC: begin
        if (bus_req_i && !timer_busy) state_d = `CPSMC_ST_BUS_REL;
        else if ((irq_req_i && !int_block_q) || trap_req_i) state_d = `CPSMC_ST_EXC;
        else if (sleep_exec_i && !sys_cfg_q[`CPSMC_STANDBY_SELECT_BIT_BIT]) state_d = `CPSMC_ST_SLEEP;
        else if (sleep_exec_i) state_d = `CPSMC_ST_SW_HW_STANDBY_INPUT_N;
      end
      `CPSMC_ST_EXC:     if (seq_cnt_q == `CPSMC_EXC_STATES) state_d = `CPSMC_ST_EXEC;
      `CPSMC_ST_BUS_REL: if (!bus_req_i) state_d = `CPSMC_ST_EXEC;
      `CPSMC_ST_SLEEP:   if (wake_i) state_d = `CPSMC_ST_EXEC;
      `CPSMC_ST_SW_HW_STANDBY_INPUT_N: if (wake_i) state_d = `CPSMC_ST_EXEC;
      `CPSMC_ST_HW_HW_STANDBY_INPUT_N: state_d = `CPSMC_ST_HW_HW_STANDBY_INPUT_N;
      default:           state_d = `CPSMC_ST_RESET;
    endcase
    if (!hw_standby_input_n_n_s) state_d = `CPSMC_ST_HW_HW_STANDBY_INPUT_N;
    else if (force_rst) state_d = `CPSMC_ST_RESET;
    else if (state_q == `CPSMC_ST_HW_HW_STANDBY_INPUT_N) state_d = `CPSMC_ST_RESET;
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= `CPSMC_ST_RESET;
      seq_cnt_q    <= 4'h0;
      res_n_prev_q <= 1'b0;
      ccr_q        <= 8'h80;
      int_block_q  <= 1'b1;
      wake_pend_q  <= 1'b0;
    end else if (ce_i) begin
      state_q      <= state_d;
      res_n_prev_q <= ~force_rst;
      wake_pend_q  <= 1'b0;
      if (state_d != state_q) seq_cnt_q <= 4'h0;
      else if (seq_cnt_q != 4'hf) seq_cnt_q <= seq_cnt_q + 4'h1;
      case (state_q)
        `CPSMC_ST_RESET: begin
          ccr_q[`CPSMC_CCR_I_BIT] <= 1'b1;
          int_block_q <= 1'b1;
        end
        `CPSMC_ST_RST_EXC: begin
          int_block_q <= 1'b1;
          wake_pend_q <= (state_d == `CPSMC_ST_EXEC);
        end
        `CPSMC_ST_EXC: begin
          // mask update after stacking, before vector fetch
          if (seq_cnt_q == 4'h4) begin
            ccr_q[`CPSMC_CCR_I_BIT] <= 1'b1;
            if (!sys_cfg_q[`CPSMC_UE_BIT]) ccr_q[`CPSMC_CCR_UI_BIT] <= 1'b1;
          end
        end
        default: ;
      endcase
      // one extra state of blocking after the reset sequence ends
      if (state_q == `CPSMC_ST_EXEC && !wake_pend_q) int_block_q <= 1'b0;
    end
  end

  // register port and access bookkeeping
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sys_cfg_q    <= `CPSMC_SYS_CFG_RST;
      area_width_q <= `CPSMC_AREA_WIDTH_RST;
      area_slow_q  <= 8'hff;
      reg_rdata_o  <= 8'h00;
      tgt_q        <= TGT_EXT;
      wide_q       <= 1'b0;
    end else if (ce_i) begin
      reg_rdata_o <= 8'h00;
      if (state_q == `CPSMC_ST_RESET) begin
        sys_cfg_q    <= `CPSMC_SYS_CFG_RST;
        area_width_q <= mode_dec[0] ? `CPSMC_AREA_WIDTH_RST : 8'h00;
      end else if (reg_wr_i) begin
        case (reg_addr_i)
          `CPSMC_OFS_SYS_CFG:    sys_cfg_q    <= reg_wdata_i;
          `CPSMC_OFS_AREA_WIDTH: area_width_q <= reg_wdata_i;
          `CPSMC_OFS_CTRL:       area_slow_q  <= reg_wdata_i;
          default: ;
        endcase
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `CPSMC_OFS_MODE_IND: begin
            reg_rdata_o  <= {`CPSMC_MODE_IND_HI, 3'h0, mode_s};
          end
          `CPSMC_OFS_SYS_CFG:    reg_rdata_o <= sys_cfg_q;
          `CPSMC_OFS_AREA_WIDTH: reg_rdata_o <= area_width_q;
          `CPSMC_OFS_CTRL:       reg_rdata_o <= area_slow_q;
          `CPSMC_OFS_STATUS:     reg_rdata_o <= {1'b0, mode_dec[3], bus_16bit_o, int_block_q, 1'b0, state_q};
          default:               reg_rdata_o <= 8'h00;
        endcase
      end
      if (acc_start) begin
        tgt_q  <= tgt_d;
        wide_q <= wide_d;
      end
    end
  end

  // registered outputs
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      proc_state_o         <= `CPSMC_ST_RESET;
      bus_grant_o          <= 1'b0;
      irq_accept_o         <= 1'b0;
      stack_push_o         <= 1'b0;
      vector_fetch_o       <= 1'b0;
      condition_code_reg_o <= 8'h80;
      periph_reset_o       <= 1'b1;
      clock_halt_o         <= 1'b0;
      cpu_halt_o           <= 1'b1;
      access_done_o        <= 1'b0;
      access_target_o      <= TGT_EXT;
      access_wide_o        <= 1'b0;
      bus_16bit_o          <= 1'b0;
      mode_legal_o         <= 1'b0;
      mode_num_o           <= 3'h0;
      space_16m_o          <= 1'b0;
      rom_enable_o         <= 1'b0;
    end else if (ce_i) begin
      proc_state_o   <= state_d;
      bus_grant_o    <= (state_d == `CPSMC_ST_BUS_REL);
      irq_accept_o   <= exec_run & (state_d == `CPSMC_ST_EXC) & irq_req_i;
      stack_push_o   <= (state_q == `CPSMC_ST_EXC) & (seq_cnt_q < 4'h4);
      vector_fetch_o <= ((state_q == `CPSMC_ST_EXC) & (seq_cnt_q > 4'h4)) |
                        (state_q == `CPSMC_ST_RST_EXC);
      condition_code_reg_o <= ccr_q;
      periph_reset_o <= (state_d == `CPSMC_ST_RESET) | (state_d == `CPSMC_ST_SW_HW_STANDBY_INPUT_N) |
                        (state_d == `CPSMC_ST_HW_HW_STANDBY_INPUT_N);
      clock_halt_o   <= (state_d == `CPSMC_ST_SW_HW_STANDBY_INPUT_N) | (state_d == `CPSMC_ST_HW_HW_STANDBY_INPUT_N);
      cpu_halt_o     <= (state_d != `CPSMC_ST_EXEC) & (state_d != `CPSMC_ST_EXC) &
                        (state_d != `CPSMC_ST_RST_EXC);
      access_done_o  <= timer_done;
      access_target_o <= tgt_q;
      access_wide_o  <= wide_q;
      bus_16bit_o    <= ~all_8bit;
      mode_legal_o   <= mode_dec[3];
      mode_num_o     <= mode_dec[3] ? mode_dec[2:0] : 3'h0;
      space_16m_o    <= (mode_dec[2:0] == 3'h3) | (mode_dec[2:0] == 3'h4);
      rom_enable_o   <= 1'b0;
    end
  end
endmodule // cpsmc_top

// *** core/cpsmc_defines.vh ***
/*
  constants for the processing-state and mode controller: register offsets,
  field positions, reset values, state codes and access timing counts.
  assumes inclusion by bare name from the core files.
*/
`ifndef CPSMC_DEFINES_VH
`define CPSMC_DEFINES_VH

`define CPSMC_ADDR_W          20
`define CPSMC_OFS_MODE_IND    20'hee011
`define CPSMC_OFS_SYS_CFG     20'hee012
`define CPSMC_OFS_AREA_WIDTH  20'hee020
`define CPSMC_OFS_CTRL        20'hee0f0
`define CPSMC_OFS_STATUS      20'hee0f1

`define CPSMC_SYS_CFG_RST     8'h09
`define CPSMC_AREA_WIDTH_RST  8'hff
`define CPSMC_MODE_IND_HI     2'h3

`define CPSMC_STANDBY_SELECT_BIT_BIT        7
`define CPSMC_UE_BIT          3
`define CPSMC_ONCHIP_RAM_ENABLE_BIT        0
`define CPSMC_CCR_I_BIT       7
`define CPSMC_CCR_UI_BIT      6

`define CPSMC_ST_RESET        3'h0
`define CPSMC_ST_RST_EXC      3'h1
`define CPSMC_ST_EXEC         3'h2
`define CPSMC_ST_EXC          3'h3
`define CPSMC_ST_BUS_REL      3'h4
`define CPSMC_ST_SLEEP        3'h5
`define CPSMC_ST_SW_HW_STANDBY_INPUT_N      3'h6
`define CPSMC_ST_HW_HW_STANDBY_INPUT_N      3'h7

`define CPSMC_STATES_FAST     2'h2
`define CPSMC_STATES_SLOW     2'h3
`define CPSMC_RST_EXC_STATES  4'h4
`define CPSMC_EXC_STATES      4'h8
`define CPSMC_POST_RST_BLOCK  4'h1

`endif

// *** core/cpsmc_sync2.v ***
/*
  two flip-flop synchroniser for a bundle of pin levels.
  assumes asynchronous pins and one system clock.
*/
`timescale 1ns/10ps
module cpsmc_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clk_sys_i,
  input  wire         rst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  // runs without clock enable so pin levels stay fresh while frozen
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule // cpsmc_sync2

// *** core/cpsmc_bus_timer.v ***
/*
  bus cycle timer: counts two or three states per access.
  assumes one-cycle start pulses while idle and one clock.
*/
`timescale 1ns/10ps
`include "cpsmc_defines.vh"
module cpsmc_bus_timer (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       start_i,
  input  wire       three_i,
  output wire       busy_o,
  output reg        done_o
);
  reg [1:0] cnt_q;
  reg [1:0] len_q;
  assign busy_o = (cnt_q != 2'h0);
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 2'h0;
      len_q  <= 2'h0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (cnt_q == 2'h0) begin
        if (start_i) begin
          cnt_q <= 2'h1;
          len_q <= three_i ? `CPSMC_STATES_SLOW : `CPSMC_STATES_FAST;
        end
      end else if (cnt_q == len_q) begin
        cnt_q  <= 2'h0;
        done_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule // cpsmc_bus_timer

// *** sim/cpsmc_top_asserts.sv ***
/*
  checker for cpsmc_top: state, exception, bus release, access timing and mode relations.
  assumes one system clock, ce_i high during accesses, bound to every cpsmc_top.
*/
`timescale 1ns/10ps
`include "cpsmc_defines.vh"
module cpsmc_checker (
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire        hw_standby_input_n_i,
  input wire [2:0]  mode_pins_i,
  input wire        wdt_overflow_i,
  input wire        bus_req_i,
  input wire        access_req_i,
  input wire [19:0] reg_addr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_rdata_o,
  input wire [2:0]  proc_state_o,
  input wire        bus_grant_o,
  input wire        irq_accept_o,
  input wire        stack_push_o,
  input wire        vector_fetch_o,
  input wire [7:0]  condition_code_reg_o,
  input wire        periph_reset_o,
  input wire        clock_halt_o,
  input wire        access_done_o,
  input wire [1:0]  access_target_o,
  input wire        mode_legal_o,
  input wire [2:0]  mode_num_o,
  input wire        space_16m_o,
  input wire        rom_enable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  wdt_reset_a: assert property (wdt_overflow_i && ce_i |=> proc_state_o == `CPSMC_ST_RESET)
    else $error("watchdog did not force reset state");
  reset_mask_a: assert property (proc_state_o == `CPSMC_ST_RESET |-> condition_code_reg_o[7])
    else $error("mask bit clear in reset state");
  irq_block_a: assert property (($past(proc_state_o) inside {`CPSMC_ST_RESET, `CPSMC_ST_RST_EXC, `CPSMC_ST_BUS_REL})
    |-> !irq_accept_o) else $error("interrupt accepted while blocked");
  rst_exc_entry_a: assert property (proc_state_o == `CPSMC_ST_RST_EXC && $past(proc_state_o) != proc_state_o
    |-> $past(proc_state_o) == `CPSMC_ST_RESET) else $error("reset sequence entered from wrong state");
  push_then_fetch_a: assert property ($fell(stack_push_o) && proc_state_o == `CPSMC_ST_EXC
    |-> !vector_fetch_o ##[1:2] vector_fetch_o) else $error("vector fetch not after stacking");
  mask_before_fetch_a: assert property ($rose(vector_fetch_o) && proc_state_o == `CPSMC_ST_EXC
    |-> condition_code_reg_o[7]) else $error("mask bit not set before vector fetch");
  grant_needs_req_a: assert property (bus_grant_o |-> $past(bus_req_i))
    else $error("grant without request");
  ram_two_a: assert property (access_done_o && access_target_o == 2'h0 |-> $past(access_req_i, 4))
    else $error("on-chip memory access not two states");
  periph_three_a: assert property (access_done_o && access_target_o == 2'h1 |-> $past(access_req_i, 5))
    else $error("peripheral access not three states");
  hw_hw_standby_input_n_a: assert property ((!hw_standby_input_n_i && ce_i)[*4]
    |-> proc_state_o == `CPSMC_ST_HW_HW_STANDBY_INPUT_N && clock_halt_o && periph_reset_o) else $error("no hardware standby");
  mode_three_a: assert property ((mode_pins_i == 3'h3)[*5]
    |-> mode_legal_o && mode_num_o == 3'h3 && space_16m_o && !rom_enable_o) else $error("mode 3 decode wrong");
  mode_bad_a: assert property ((mode_pins_i == 3'h0)[*5] |-> !mode_legal_o)
    else $error("prohibited mode taken as legal");
  mode_read_a: assert property (reg_rd_i && ce_i && reg_addr_i == `CPSMC_OFS_MODE_IND
    |=> reg_rdata_o[7:3] == 5'h18) else $error("mode indicator fixed bits wrong");
endmodule // cpsmc_checker

bind cpsmc_top cpsmc_checker i_cpsmc_checker (
  .clk_sys_i, .rst_i, .ce_i, .hw_standby_input_n_i, .mode_pins_i, .wdt_overflow_i, .bus_req_i,
  .access_req_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .proc_state_o, .bus_grant_o, .irq_accept_o,
  .stack_push_o, .vector_fetch_o, .condition_code_reg_o, .periph_reset_o, .clock_halt_o,
  .access_done_o, .access_target_o, .mode_legal_o, .mode_num_o, .space_16m_o, .rom_enable_o
);

// *** sim/cpsmc_ext_master.sv ***
/*
  external bus master model: requests the bus, holds it, hands it back.
  assumes the grant is a registered level on the system clock.
*/
`timescale 1ns/10ps
module cpsmc_ext_master #(
  parameter integer HOLD = 8
) (
  input  wire clk_sys_i,
  input  wire go_i,
  input  wire grant_i,
  output reg  bus_req_o,
  output reg  done_o
);
  integer n;
  initial begin
    bus_req_o = 1'b0;
    done_o    = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      done_o <= 1'b0;
      if (go_i === 1'b1) begin
        // request held until grant seen or 20 cycles pass, then until hold spent; no early drop
        bus_req_o <= 1'b1;
        n = 0;
        while (grant_i !== 1'b1 && n < 20) begin
          @(posedge clk_sys_i);
          n = n + 1;
        end
        repeat (HOLD) @(posedge clk_sys_i);
        bus_req_o <= 1'b0;
        done_o    <= (n < 20);
      end
    end
  end
endmodule // cpsmc_ext_master

// *** sim/cpsmc_top_tb.sv ***
/*
  self-checking bench for cpsmc_top: modes, registers, exceptions, bus release, power-down, access timing.
  assumes the checker is bound and the external master model is compiled alongside.
*/
`timescale 1ns/10ps
`include "cpsmc_defines.vh"
module cpsmc_top_tb;
  reg         clk_sys_i, rst_i, ce_i, reset_input_n_i, hw_standby_input_n_i, ext_go;
  reg         wdt_overflow_i, irq_req_i, trap_req_i, sleep_exec_i, wake_i, access_req_i, reg_wr_i, reg_rd_i;
  reg  [2:0]  mode_pins_i, access_area_i;
  reg  [23:0] access_addr_i;
  reg  [19:0] reg_addr_i;
  reg  [7:0]  reg_wdata_i, d;
  wire        bus_req_i, ext_done, bus_grant_o, irq_accept_o, stack_push_o, vector_fetch_o, periph_reset_o;
  wire        clock_halt_o, cpu_halt_o, access_done_o, access_wide_o, bus_16bit_o, mode_legal_o;
  wire        space_16m_o, rom_enable_o;
  wire [7:0]  reg_rdata_o, condition_code_reg_o;
  wire [2:0]  proc_state_o, mode_num_o;
  wire [1:0]  access_target_o;
  integer     error_cnt, checks;

  // ranges tied: decode of ram versus peripheral versus external is what matters
  cpsmc_top i_cpsmc_top (.clk_sys_i, .rst_i, .ce_i, .reset_input_n_i, .hw_standby_input_n_i, .mode_pins_i,
    .wdt_overflow_i, .bus_req_i, .irq_req_i, .trap_req_i, .sleep_exec_i, .wake_i, .access_req_i, .access_addr_i,
    .ram_base_i(24'h000100), .ram_limit_i(24'h0001ff), .periph_base_i(24'h000200), .periph_limit_i(24'h0002ff),
    .access_area_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .proc_state_o, .bus_grant_o,
    .irq_accept_o, .stack_push_o, .vector_fetch_o, .condition_code_reg_o, .periph_reset_o, .clock_halt_o,
    .cpu_halt_o, .access_done_o, .access_target_o, .access_wide_o, .bus_16bit_o, .mode_legal_o, .mode_num_o,
    .space_16m_o, .rom_enable_o);
  cpsmc_ext_master i_cpsmc_ext_master (.clk_sys_i, .go_i(ext_go), .grant_i(bus_grant_o), .bus_req_o(bus_req_i),
    .done_o(ext_done));

  always #10 clk_sys_i = ~clk_sys_i;

  task end_of_test;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wait_st(input [2:0] s);
    integer n;
    n = 0;
    while (proc_state_o !== s) begin
      @(posedge clk_sys_i);
      n = n + 1;
      if (n > 300) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t state %0d not reached", $time, s);
        end_of_test;
      end
    end
  endtask

  task wr(input [19:0] a, input [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task rd(input [19:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    d = reg_rdata_o;
  endtask

  task t_mode(input [2:0] p);
    rst_i <= 1'b1;
    mode_pins_i <= p;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    if (p == 3'h0) begin
      repeat (8) @(posedge clk_sys_i);
      chk(mode_legal_o, 0);
    end else begin
      wait_st(`CPSMC_ST_EXEC);
      chk({mode_legal_o, mode_num_o, space_16m_o, rom_enable_o}, {1'b1, p, p > 3'h2, 1'b0});
      chk(bus_16bit_o, !p[0]);
      rd(`CPSMC_OFS_MODE_IND);
      chk(d, {5'h18, p});
    end
  endtask

  task t_exc(input [1:0] m);
    integer n;
    reg pushed;
    wait_st(`CPSMC_ST_EXC);
    chk(irq_accept_o, irq_req_i);
    irq_req_i <= 1'b0;
    pushed = 1'b0;
    n = 0;
    while (vector_fetch_o !== 1'b1 && n < 20) begin
      pushed = pushed | stack_push_o;
      @(posedge clk_sys_i);
      n = n + 1;
    end
    chk({pushed, vector_fetch_o}, 2'h3);
    chk(condition_code_reg_o[7:6], m);
    wait_st(`CPSMC_ST_EXEC);
  endtask

  task t_bus;
    integer n, hits;
    ext_go <= 1'b1;
    @(posedge clk_sys_i);
    ext_go <= 1'b0;
    wait_st(`CPSMC_ST_BUS_REL);
    chk(bus_grant_o, 1);
    irq_req_i <= 1'b1;
    n = 0;
    hits = 0;
    while (ext_done !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n = n + 1;
      if (bus_grant_o === 1'b1 && irq_accept_o === 1'b1) hits = hits + 1;
    end
    chk({hits[3:0], ext_done}, 5'h01);
    t_exc(2'h3);
  endtask

  task t_sleep(input [2:0] s, input [1:0] hp);
    sleep_exec_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_exec_i <= 1'b0;
    wait_st(s);
    chk({cpu_halt_o, clock_halt_o, periph_reset_o}, {1'b1, hp});
    wake_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_i <= 1'b0;
    wait_st(`CPSMC_ST_EXEC);
  endtask

  task acc(input [23:0] a, input [2:0] ar, input integer st, input [1:0] tg, input [1:0] wd);
    integer n;
    access_addr_i <= a;
    access_area_i <= ar;
    access_req_i <= 1'b1;
    @(posedge clk_sys_i);
    access_req_i <= 1'b0;
    n = 1;
    while (access_done_o !== 1'b1 && n < 10) begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
    chk(n, st + 3);
    chk(access_target_o, tg);
    if (wd != 2'h2) chk(access_wide_o, wd[0]);
  endtask

  initial begin
    clk_sys_i = 1'b0; rst_i = 1'b1; ce_i = 1'b1; reset_input_n_i = 1'b1; hw_standby_input_n_i = 1'b1;
    ext_go = 1'b0; wdt_overflow_i = 1'b0; irq_req_i = 1'b0; trap_req_i = 1'b0; sleep_exec_i = 1'b0;
    wake_i = 1'b0; access_req_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; mode_pins_i = 3'h1;
    access_area_i = 3'h0; access_addr_i = 24'h000000; reg_addr_i = 20'h00000; reg_wdata_i = 8'h00;
    error_cnt = 0; checks = 0;
    @(posedge clk_sys_i);
    t_mode(3'h0); t_mode(3'h2); t_mode(3'h3); t_mode(3'h4); t_mode(3'h1);
    rd(`CPSMC_OFS_SYS_CFG);
    chk(d, 8'h09);
    wr(`CPSMC_OFS_MODE_IND, 8'h00);
    rd(`CPSMC_OFS_MODE_IND);
    chk(d, 8'hc1);
    rd(20'h00000);
    chk(d, 8'h00);
    reset_input_n_i <= 1'b0;
    irq_req_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk({proc_state_o, condition_code_reg_o[7]}, {`CPSMC_ST_RESET, 1'b1});
    reset_input_n_i <= 1'b1;
    wait_st(`CPSMC_ST_RST_EXC);
    chk(irq_accept_o, 0);
    wait_st(`CPSMC_ST_EXEC);
    chk(irq_accept_o, 0);
    t_exc(2'h2);
    // user enable off: second mask bit joins the mask
    wr(`CPSMC_OFS_SYS_CFG, 8'h01);
    trap_req_i <= 1'b1;
    @(posedge clk_sys_i);
    trap_req_i <= 1'b0;
    t_exc(2'h3);
    t_bus;
    t_sleep(`CPSMC_ST_SLEEP, 2'h0);
    wr(`CPSMC_OFS_SYS_CFG, 8'h81);
    t_sleep(`CPSMC_ST_SW_HW_STANDBY_INPUT_N, 2'h3);
    rd(`CPSMC_OFS_SYS_CFG);
    chk({d, condition_code_reg_o[7:6]}, {8'h81, 2'h3});
    // standby is left through the reset pin, held low until standby ends
    hw_standby_input_n_i <= 1'b0;
    reset_input_n_i <= 1'b0;
    wait_st(`CPSMC_ST_HW_HW_STANDBY_INPUT_N);
    chk({clock_halt_o, periph_reset_o}, 2'h3);
    hw_standby_input_n_i <= 1'b1;
    wait_st(`CPSMC_ST_RESET);
    reset_input_n_i <= 1'b1;
    wait_st(`CPSMC_ST_EXEC);
    wdt_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_overflow_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(proc_state_o, `CPSMC_ST_RESET);
    wait_st(`CPSMC_ST_EXEC);
    wr(`CPSMC_OFS_AREA_WIDTH, 8'hff);
    wr(`CPSMC_OFS_CTRL, 8'hff);
    acc(24'h000140, 3'h0, 2, 2'h0, 2'h1);
    acc(24'h000210, 3'h0, 3, 2'h1, 2'h2);
    acc(24'h400000, 3'h5, 3, 2'h2, 2'h0);
    chk(bus_16bit_o, 0);
    wr(`CPSMC_OFS_CTRL, 8'hfb);
    wr(`CPSMC_OFS_AREA_WIDTH, 8'hfb);
    @(posedge clk_sys_i);
    chk(bus_16bit_o, 1);
    acc(24'h400000, 3'h2, 2, 2'h2, 2'h1);
    wr(`CPSMC_OFS_SYS_CFG, 8'h08);
    acc(24'h000140, 3'h0, 3, 2'h2, 2'h0);
    end_of_test;
  end
endmodule // cpsmc_top_tb
